// ---- common/code_security_lock_pkg.sv ----
// Constants, pin codes and carrier types for the code security lock.
// Assumes one 200 MHz clock domain and a byte-wide program memory port.
package code_security_lock_pkg;

    // ------------------------------------------------------------
    // Pin mode codes decoded by the pad ring
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_VERIFY_CODE = 3'h1;
    localparam logic [2:0] MODE_PROGRAM_STROBE_CODE = 3'h2;
    localparam logic [2:0] MODE_PROGRAM_STROBE_KEY = 3'h3;
    localparam logic [2:0] MODE_PROGRAM_STROBE_LOCK_ONE = 3'h4;
    localparam logic [2:0] MODE_PROGRAM_STROBE_LOCK_TWO = 3'h5;
    localparam logic [2:0] MODE_VERIFY_LOCK = 3'h6;

    // ------------------------------------------------------------
    // Programming and image layout
    // ------------------------------------------------------------
    localparam logic [2:0] PULSES_PER_WRITE = 3'h5;
    localparam logic [1:0] CODE_SEL_4K = 2'h0;
    localparam logic [1:0] CODE_SEL_8K = 2'h1;
    localparam logic [15:0] CODE_END_4K = 16'h0FFF;
    localparam logic [15:0] CODE_END_8K = 16'h1FFF;
    localparam logic [15:0] CODE_END_16K = 16'h3FFF;
    localparam logic [15:0] KEY_REGION_BYTES = 16'h0040;
    localparam logic [15:0] ONE_BYTE = 16'h0001;
    localparam int KEY_DEPTH = 64;
    localparam int KEY_IDX_W = 6;
    localparam logic [5:0] KEY_MASK_64 = 6'h3F;
    localparam logic [5:0] KEY_MASK_32 = 6'h1F;
    localparam logic [7:0] BYTE_BLANK = 8'hFF;
    localparam int LOCK_ONE_POS = 0;
    localparam int LOCK_TWO_POS = 1;
    localparam int VFY_ONE_POS = 7;
    localparam int VFY_TWO_POS = 6;
    localparam int VFY_THREE_POS = 3;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int CFG_CODE_LSB = 0;
    localparam int CFG_KEY_HALF_POS = 2;
    localparam int ST_LOCK_ONE = 0;
    localparam int ST_LOCK_TWO = 1;
    localparam int ST_KEY_PROGRAM_STROBE = 2;
    localparam int ST_EXT_ACCESS = 3;
    localparam int ST_REFUSED = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic strobe_n;
        logic [2:0] mode;
        logic [15:0] addr;
        logic [7:0] data;
        logic ext_access;
    } pin_s;

    localparam pin_s PIN_IDLE = '{strobe_n: 1'b1, mode: MODE_IDLE, addr: 16'h0000,
                                  data: 8'h00, ext_access: 1'b1};

    typedef struct packed {
        logic lock_one;
        logic lock_two;
        logic key_program_strobe;
    } prot_s;

endpackage

// ---- rtl/key_table_mem.sv ----
// Scrambling key table: 64 bytes, one write port, registered read data.
// Assumes the caller masks the index for the 32-byte variant.
`timescale 1ns/1ps
module key_table_mem (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [code_security_lock_pkg::KEY_IDX_W-1:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    // Read port
    input wire logic [code_security_lock_pkg::KEY_IDX_W-1:0] rd_idx_in,
    output logic [7:0] rd_data_out
);
    import code_security_lock_pkg::*;

    logic [7:0] key_ff [KEY_DEPTH];

    // Reset stands for the erased array, so every byte comes up blank.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < KEY_DEPTH; i++) begin
                key_ff[i] <= BYTE_BLANK;
            end
        end else if (wr_en_in) begin
            key_ff[wr_idx_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= BYTE_BLANK;
        end else begin
            rd_data_out <= key_ff[rd_idx_in];
        end
    end

endmodule

// ---- rtl/code_security_lock.sv ----
// Code security lock: lock bits, key scrambling, verify and program gating.
// Assumes a program memory that returns read data one cycle after code_rd_out,
// programmer pins that are asynchronous, and a CPU on clk_in.
//
// Overview of operation
// - No lock bits: verify reads code back.
// - Programmed key scrambles every code verify read, not lock verify.
// - Lock one blocks external table reads inside.
// - Lock one latches external access at reset.
// - Lock one refuses further code programming.
// - Both lock bits also disable code verify.
// - Key table starts blank, 64 or 32 bytes.
// - Undefined lock combinations need no support.
// - Lock two counts only with lock one.
// - Key region follows code in image.
// - Lock byte: bit0 one, bit1 two, 0 enables.
// - Code spans 4/8/16 KB from zero.
// - Key byte all ones means no scrambling.
// - Verified byte is code XNOR key byte.
// - Lock verify puts bits on 7, 6, 3.
`timescale 1ns/1ps
module code_security_lock (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Programmer pins, asynchronous
    input wire code_security_lock_pkg::pin_s pins_in,
    output logic [7:0] data_pin_out,
    output logic data_pin_oe_n_out,
    // Program memory port
    output logic [15:0] code_addr_out,
    output logic code_rd_out,
    output logic code_wr_out,
    output logic [7:0] code_wdata_out,
    input wire logic [7:0] code_data_in,
    // CPU table reads
    input wire logic table_req_in,
    input wire logic table_from_ext_in,
    input wire logic [15:0] table_addr_in,
    output logic table_deny_out,
    output logic ext_access_latched_out,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out
);
    import code_security_lock_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_BOOT_RD = 5'b00001,
        ST_BOOT_WAIT = 5'b00010,
        ST_BOOT_CAP = 5'b00100,
        ST_IDLE = 5'b01000,
        ST_COUNT = 5'b10000
    } state_e;

    state_e state_ff;
    pin_s sync1_ff;
    pin_s pins_ff;
    logic strobe_prev_ff;
    logic [2:0] pulse_cnt_ff;
    logic [2:0] program_strobe_mode_ff;
    logic [15:0] program_strobe_addr_ff;
    logic [7:0] program_strobe_data_ff;
    prot_s prot_ff;
    logic [1:0] lock_raw_ff;
    logic refused_ff;
    logic [7:0] config_ff;
    logic vfy_s1_ff;
    logic vfy_s2_ff;
    logic lock_vfy_ff;
    logic [KEY_IDX_W-1:0] key_idx_ff;
    logic [7:0] key_rd_data;
    logic [15:0] code_end;
    logic [15:0] lock_addr;
    logic [5:0] key_mask;
    logic strobe_fall;
    logic strobe_rise;
    logic program_strobe_done;
    logic is_program_strobe_mode;
    logic verify_ok;
    logic key_wr;
    logic code_commit;

    // ------------------------------------------------------------
    // Pin synchroniser and decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1_ff <= PIN_IDLE;
            pins_ff <= PIN_IDLE;
            strobe_prev_ff <= 1'b1;
        end else begin
            sync1_ff <= pins_in;
            pins_ff <= sync1_ff;
            strobe_prev_ff <= pins_ff.strobe_n;
        end
    end

    always_comb begin
        unique case (config_ff[CFG_CODE_LSB +: 2])
            CODE_SEL_4K: code_end = CODE_END_4K;
            CODE_SEL_8K: code_end = CODE_END_8K;
            default: code_end = CODE_END_16K;
        endcase
    end

    // Key region starts right after the code, lock byte right after the key.
    assign lock_addr = code_end + ONE_BYTE + KEY_REGION_BYTES;
    assign key_mask = config_ff[CFG_KEY_HALF_POS] ? KEY_MASK_32 : KEY_MASK_64;
    assign strobe_fall = strobe_prev_ff && !pins_ff.strobe_n;
    assign strobe_rise = !strobe_prev_ff && pins_ff.strobe_n;
    assign is_program_strobe_mode = (pins_ff.mode == MODE_PROGRAM_STROBE_CODE) || (pins_ff.mode == MODE_PROGRAM_STROBE_KEY)
        || (pins_ff.mode == MODE_PROGRAM_STROBE_LOCK_ONE) || (pins_ff.mode == MODE_PROGRAM_STROBE_LOCK_TWO);
    // Lock two alone is ignored, and no other combination is given meaning.
    assign verify_ok = !(prot_ff.lock_one && prot_ff.lock_two);

    // ------------------------------------------------------------
    // Boot and programming sequence
    // ------------------------------------------------------------
    // A write commits at the end of the fifth strobe pulse while the mode holds.
    assign program_strobe_done = (state_ff == ST_COUNT) && strobe_rise
        && (pins_ff.mode == program_strobe_mode_ff)
        && (pulse_cnt_ff == PULSES_PER_WRITE - 3'h1);
    // Lock bits stay programmable after lock one, code and key do not.
    assign code_commit = program_strobe_done && ((program_strobe_mode_ff == MODE_PROGRAM_STROBE_LOCK_ONE)
        || (program_strobe_mode_ff == MODE_PROGRAM_STROBE_LOCK_TWO)
        || ((program_strobe_mode_ff == MODE_PROGRAM_STROBE_CODE) && !prot_ff.lock_one));
    assign key_wr = program_strobe_done && (program_strobe_mode_ff == MODE_PROGRAM_STROBE_KEY) && !prot_ff.lock_one;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= ST_BOOT_RD;
            pulse_cnt_ff <= 3'h0;
            program_strobe_mode_ff <= MODE_IDLE;
            program_strobe_addr_ff <= 16'h0000;
            program_strobe_data_ff <= BYTE_BLANK;
        end else begin
            unique case (state_ff)
                ST_BOOT_RD: state_ff <= ST_BOOT_WAIT;
                ST_BOOT_WAIT: state_ff <= ST_BOOT_CAP;
                ST_BOOT_CAP: state_ff <= ST_IDLE;
                ST_IDLE: begin
                    if (is_program_strobe_mode && strobe_fall) begin
                        state_ff <= ST_COUNT;
                        pulse_cnt_ff <= 3'h0;
                        program_strobe_mode_ff <= pins_ff.mode;
                        program_strobe_addr_ff <= pins_ff.addr;
                        program_strobe_data_ff <= pins_ff.data;
                    end
                end
                ST_COUNT: begin
                    if (pins_ff.mode != program_strobe_mode_ff || program_strobe_done) begin
                        state_ff <= ST_IDLE;
                    end else if (strobe_rise) begin
                        pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Protection state, sampled once after reset
    // ------------------------------------------------------------
    // The flags only change at boot, so a lock programmed now takes hold after
    // the next reset; the key flag is the one exception, it follows writes.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prot_ff <= '{lock_one: 1'b0, lock_two: 1'b0, key_program_strobe: 1'b0};
            lock_raw_ff <= 2'h3;
        end else begin
            if (state_ff == ST_BOOT_CAP) begin
                lock_raw_ff <= code_data_in[LOCK_TWO_POS:LOCK_ONE_POS];
                prot_ff.lock_one <= !code_data_in[LOCK_ONE_POS];
                prot_ff.lock_two <= !code_data_in[LOCK_TWO_POS];
            end
            // A blank byte scrambles nothing, so only a non-blank key counts.
            if (key_wr && program_strobe_data_ff != BYTE_BLANK) begin
                prot_ff.key_program_strobe <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_access_latched_out <= 1'b1;
        end else if (state_ff == ST_BOOT_CAP || !prot_ff.lock_one) begin
            ext_access_latched_out <= pins_ff.ext_access;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            table_deny_out <= 1'b0;
        end else begin
            table_deny_out <= table_req_in && table_from_ext_in && prot_ff.lock_one
                && (table_addr_in <= code_end);
        end
    end

    // ------------------------------------------------------------
    // Program memory port and verify pipeline
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            code_addr_out <= 16'h0000;
            code_rd_out <= 1'b0;
            code_wr_out <= 1'b0;
            code_wdata_out <= BYTE_BLANK;
            vfy_s1_ff <= 1'b0;
            key_idx_ff <= '0;
        end else begin
            code_rd_out <= 1'b0;
            code_wr_out <= 1'b0;
            vfy_s1_ff <= 1'b0;
            if (state_ff == ST_BOOT_RD) begin
                code_addr_out <= lock_addr;
                code_rd_out <= 1'b1;
            end else if (code_commit) begin
                code_wr_out <= 1'b1;
                unique case (program_strobe_mode_ff)
                    MODE_PROGRAM_STROBE_LOCK_ONE: begin
                        code_addr_out <= lock_addr;
                        code_wdata_out <= BYTE_BLANK & ~(8'h01 << LOCK_ONE_POS);
                    end
                    MODE_PROGRAM_STROBE_LOCK_TWO: begin
                        code_addr_out <= lock_addr;
                        code_wdata_out <= BYTE_BLANK & ~(8'h01 << LOCK_TWO_POS);
                    end
                    default: begin
                        code_addr_out <= program_strobe_addr_ff;
                        code_wdata_out <= program_strobe_data_ff;
                    end
                endcase
            end else if (state_ff == ST_IDLE && pins_ff.mode == MODE_VERIFY_CODE
                         && verify_ok) begin
                code_addr_out <= pins_ff.addr;
                code_rd_out <= 1'b1;
                vfy_s1_ff <= 1'b1;
                key_idx_ff <= pins_ff.addr[KEY_IDX_W-1:0] & key_mask;
            end
        end
    end

    key_table_mem u_key_table (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .wr_en_in(key_wr),
        .wr_idx_in(program_strobe_addr_ff[KEY_IDX_W-1:0] & key_mask),
        .wr_data_in(program_strobe_data_ff),
        .rd_idx_in(key_idx_ff),
        .rd_data_out(key_rd_data)
    );

    // The key table has no read path of its own; it only ever shows up mixed
    // into verify data, which is what keeps it secret.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            vfy_s2_ff <= 1'b0;
            lock_vfy_ff <= 1'b0;
            data_pin_out <= BYTE_BLANK;
            data_pin_oe_n_out <= 1'b1;
        end else begin
            vfy_s2_ff <= vfy_s1_ff;
            lock_vfy_ff <= (state_ff == ST_IDLE) && (pins_ff.mode == MODE_VERIFY_LOCK);
            data_pin_oe_n_out <= 1'b1;
            if (vfy_s2_ff) begin
                data_pin_oe_n_out <= 1'b0;
                if (prot_ff.key_program_strobe) begin
                    data_pin_out <= ~(code_data_in ^ key_rd_data);
                end else begin
                    data_pin_out <= code_data_in;
                end
            end else if (lock_vfy_ff) begin
                data_pin_oe_n_out <= 1'b0;
                data_pin_out <= BYTE_BLANK;
                data_pin_out[VFY_ONE_POS] <= lock_raw_ff[LOCK_ONE_POS];
                data_pin_out[VFY_TWO_POS] <= lock_raw_ff[LOCK_TWO_POS];
                data_pin_out[VFY_THREE_POS] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            config_ff <= CONFIG_RESET;
        end else if (reg_wr_in && reg_addr_in == REG_CONFIG) begin
            config_ff <= reg_wdata_in;
        end
    end

    // A refusal in the same cycle as a clear still lands.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            refused_ff <= 1'b0;
        end else if (program_strobe_done && !code_commit && !key_wr) begin
            refused_ff <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[ST_REFUSED]) begin
            refused_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= 8'h00;
            if (reg_rd_in && reg_addr_in == REG_CONFIG) begin
                reg_rdata_out <= config_ff;
            end else if (reg_rd_in && reg_addr_in == REG_STATUS) begin
                reg_rdata_out[ST_LOCK_ONE] <= prot_ff.lock_one;
                reg_rdata_out[ST_LOCK_TWO] <= prot_ff.lock_two;
                reg_rdata_out[ST_KEY_PROGRAM_STROBE] <= prot_ff.key_program_strobe;
                reg_rdata_out[ST_EXT_ACCESS] <= ext_access_latched_out;
                reg_rdata_out[ST_REFUSED] <= refused_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking dflt_cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_verify_lock_off: assert property (
        vfy_s1_ff |-> !(prot_ff.lock_one && prot_ff.lock_two))
        else $error("code verify ran with both lock bits set");

    a_scramble_xnor: assert property (
        vfy_s2_ff && prot_ff.key_program_strobe |=>
        data_pin_out == ~($past(code_data_in) ^ $past(key_rd_data)) && !data_pin_oe_n_out)
        else $error("scrambled verify byte is not code xnor key");

    a_plain_read: assert property (
        vfy_s2_ff && !prot_ff.key_program_strobe |=> data_pin_out == $past(code_data_in))
        else $error("plain verify byte differs from code byte");

    a_verify_latency: assert property (
        state_ff == ST_IDLE && pins_ff.mode == MODE_VERIFY_CODE && verify_ok
        |=> code_rd_out ##2 !data_pin_oe_n_out)
        else $error("verify byte not driven three cycles after request");

    a_table_block: assert property (
        table_req_in && table_from_ext_in && prot_ff.lock_one && table_addr_in <= code_end
        |=> table_deny_out)
        else $error("external table read of internal code not denied");

    a_access_hold: assert property (
        state_ff == ST_IDLE && prot_ff.lock_one |=> $stable(ext_access_latched_out))
        else $error("latched external access changed while locked");

    a_program_strobe_refused: assert property (
        program_strobe_done && prot_ff.lock_one && program_strobe_mode_ff == MODE_PROGRAM_STROBE_CODE
        |=> !code_wr_out && refused_ff)
        else $error("code write went through with lock one set");

    a_lock_vfy_bits: assert property (
        state_ff == ST_IDLE && pins_ff.mode == MODE_VERIFY_LOCK && !vfy_s1_ff |=> ##1
        data_pin_out[VFY_ONE_POS] == lock_raw_ff[LOCK_ONE_POS]
        && data_pin_out[VFY_TWO_POS] == lock_raw_ff[LOCK_TWO_POS])
        else $error("lock bits not placed on the data pins");

    a_prot_stable: assert property (
        state_ff == ST_IDLE |=> $stable(prot_ff.lock_one) && $stable(prot_ff.lock_two))
        else $error("lock flags changed after boot");

    c_scrambled_verify: cover property (vfy_s2_ff && prot_ff.key_program_strobe);
    c_refused_write: cover property (program_strobe_done && !code_commit && !key_wr);
    c_lock_verify: cover property (lock_vfy_ff ##1 !data_pin_oe_n_out);

endmodule

// ---- verif/code_mem_model.sv ----
// Program memory model that sits behind the code security lock.
// Assumes a read pulse is answered in the next cycle and writes only clear bits.
`timescale 1ns/1ps
module code_mem_model (
    // Clock
    input wire logic clk_in,
    // Memory port
    input wire logic [15:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] data_out
);
    logic [7:0] mem [65536];
    // Code bytes follow a pattern; the key region and the lock byte start blank.
    initial begin
        data_out = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = (i >= 32'h1000) ? 8'hFF : (i[7:0] ^ 8'h3C);
        end
    end
    always @(posedge clk_in) begin
        if (rd_in) begin
            data_out <= mem[addr_in];
        end else begin
            // A stale value must never look valid outside the answer cycle.
            data_out <= ~data_out;
        end
        if (wr_in) begin
            mem[addr_in] <= mem[addr_in] & wdata_in;
        end
    end
endmodule

// ---- verif/code_security_lock_bench.sv ----
// Self-checking bench for the code security lock.
// Assumes the memory model answers reads and the pins pass a two-flop sync.
`timescale 1ns/1ps
module code_security_lock_bench;
    import code_security_lock_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    pin_s pins = PIN_IDLE;
    logic [7:0] dpin, cwdata, cdata, rdata, rwdata;
    logic [7:0] raddr = 8'h00;
    logic [15:0] caddr, va;
    logic [15:0] taddr = 16'h0000;
    logic oe_n, crd, cwr, deny, eal, rd_d, oe_d;
    logic treq = 1'b0, text = 1'b0, rwr = 1'b0, rrd = 1'b0;
    logic [7:0] kv;
    logic [7:0] notes [$];
    int seed = 32'h09a5ecf6;
    int fails = 0;
    int comparisons = 0;
    always #2.5 clk_in = ~clk_in;
    code_security_lock dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .pins_in(pins),
        .data_pin_out(dpin), .data_pin_oe_n_out(oe_n), .code_addr_out(caddr),
        .code_rd_out(crd), .code_wr_out(cwr), .code_wdata_out(cwdata),
        .code_data_in(cdata), .table_req_in(treq), .table_from_ext_in(text),
        .table_addr_in(taddr), .table_deny_out(deny), .ext_access_latched_out(eal),
        .reg_addr_in(raddr), .reg_wdata_in(rwdata), .reg_wr_in(rwr), .reg_rd_in(rrd),
        .reg_rdata_out(rdata));
    code_mem_model mem_u (.clk_in(clk_in), .addr_in(caddr), .rd_in(crd), .wr_in(cwr),
        .wdata_in(cwdata), .data_out(cdata));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read data and a fresh data-port drive are compared with the oldest note.
    always @(posedge clk_in) begin
        rd_d <= rrd;
        oe_d <= oe_n;
        if (rd_d === 1'b1) check(rdata, notes.pop_front());
        if (oe_d === 1'b1 && oe_n === 1'b0) check(dpin, notes.pop_front());
    end
    task automatic do_reset();
        reset_n_in <= 1'b0;
        tick(16);
        reset_n_in <= 1'b1;
        tick(8);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        notes.push_back(e);
        raddr <= a;
        rrd <= 1'b1;
        tick(1);
        rrd <= 1'b0;
        tick(2);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        raddr <= a;
        rwdata <= d;
        rwr <= 1'b1;
        tick(1);
        rwr <= 1'b0;
        tick(1);
    endtask
    task automatic verify(input logic [2:0] m, input logic [15:0] a, input logic [7:0] e);
        notes.push_back(e);
        pins.mode <= m;
        pins.addr <= a;
        tick(12);
        pins.mode <= MODE_IDLE;
        tick(6);
    endtask
    task automatic program_strobe(input logic [2:0] m, input logic [15:0] a, input logic [7:0] d);
        pins.mode <= m;
        pins.addr <= a;
        pins.data <= d;
        tick(4);
        repeat (5) begin
            pins.strobe_n <= 1'b0;
            tick(4);
            pins.strobe_n <= 1'b1;
            tick(4);
        end
        pins.mode <= MODE_IDLE;
        tick(6);
    endtask
    task automatic table_rd(input logic [15:0] a, input logic e);
        treq <= 1'b1;
        text <= 1'b1;
        taddr <= a;
        tick(1);
        treq <= 1'b0;
        tick(1);
        check({7'h00, deny}, {7'h00, e});
        tick(1);
    endtask
    task automatic access_try(input logic e);
        pins.ext_access <= 1'b0;
        tick(6);
        check({7'h00, eal}, {7'h00, e});
        pins.ext_access <= 1'b1;
        tick(6);
    endtask
    task automatic print_verdict();
        $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        kv = $random(seed);
        kv[7] = 1'b0;
        va = $random(seed);
        va = {4'h0, va[11:6], 6'h05};
        do_reset();
        reg_rd(REG_STATUS, 8'h08);
        reg_rd(8'h7E, 8'h00);
        verify(MODE_VERIFY_CODE, va, va[7:0] ^ 8'h3C);
        verify(MODE_VERIFY_LOCK, 16'h0000, 8'hFF);
        table_rd(16'h0100, 1'b0);
        access_try(1'b0);
        $display("Test done: open device");
        program_strobe(MODE_PROGRAM_STROBE_KEY, 16'h0005, kv);
        reg_rd(REG_STATUS, 8'h0C);
        verify(MODE_VERIFY_CODE, va, ~((va[7:0] ^ 8'h3C) ^ kv));
        verify(MODE_VERIFY_CODE, 16'h0006, 8'h06 ^ 8'h3C);
        reg_wr(REG_CONFIG, 8'h04);
        verify(MODE_VERIFY_CODE, 16'h0025, ~((8'h25 ^ 8'h3C) ^ kv));
        $display("Test done: key scrambling");
        program_strobe(MODE_PROGRAM_STROBE_LOCK_ONE, 16'h0000, 8'h00);
        do_reset();
        reg_rd(REG_STATUS, 8'h09);
        access_try(1'b1);
        table_rd(16'h0FFF, 1'b1);
        table_rd(16'h1000, 1'b0);
        program_strobe(MODE_PROGRAM_STROBE_CODE, 16'h0010, 8'h00);
        reg_rd(REG_STATUS, 8'h19);
        verify(MODE_VERIFY_CODE, 16'h0010, 8'h10 ^ 8'h3C);
        reg_wr(REG_STATUS, 8'h10);
        reg_rd(REG_STATUS, 8'h09);
        verify(MODE_VERIFY_LOCK, 16'h0000, 8'h7F);
        $display("Test done: first lock");
        program_strobe(MODE_PROGRAM_STROBE_LOCK_TWO, 16'h0000, 8'h00);
        do_reset();
        reg_rd(REG_STATUS, 8'h0B);
        pins.mode <= MODE_VERIFY_CODE;
        tick(12);
        check({7'h00, oe_n}, 8'h01);
        pins.mode <= MODE_IDLE;
        tick(6);
        verify(MODE_VERIFY_LOCK, 16'h0000, 8'h3F);
        $display("Test done: both locks");
        print_verdict();
    end
    initial begin
        tick(20000);
        fails++;
        print_verdict();
    end
endmodule
